//--- sop_pkg.sv
// Package of constants and types for the system option block.
//==================================================================
// Overview of operation
// - Monitor runs in stop only if stop-enabled.
// - Reset-disable option suppresses monitor reset output.
// - Power-disable option powers the monitor down.
// - Trip select: 1 picks 5 V, 0 picks 3.3 V.
// - Trip select cleared only by power-on reset.
// - Stop recovery lasts 32 or 4096 cycles.
// - Monitor reset in stop forces long recovery.
// - Power-on reset gives 4096-cycle stabilization.
// - Halt executes if enabled, else illegal opcode.
// - Watchdog-disable option stops the watchdog.
//==================================================================
package sop_pkg;

   //==============================================================
   // Register map.
   //==============================================================
   localparam logic [7:0] SOP_OFS_OPTION = 8'h00; // Option register.
   localparam logic [7:0] SOP_OFS_STATUS = 8'h04; // Sequencer status.

   // Field positions of the option register.
   localparam int SOP_BIT_WDOG_DIS   = 0; // Watchdog disable.
   localparam int SOP_BIT_HALT_EN    = 1; // Halt instruction enable.
   localparam int SOP_BIT_SHORT_REC  = 2; // Short stop recovery.
   localparam int SOP_BIT_TRIP_SEL   = 3; // Monitor trip select.
   localparam int SOP_BIT_PWR_DIS    = 4; // Monitor power disable.
   localparam int SOP_BIT_RST_DIS    = 5; // Monitor reset disable.
   localparam int SOP_BIT_STOP_EN    = 6; // Monitor enable in stop.

   // Field positions of the status register.
   localparam int SOP_BIT_ST_STOP    = 0; // Device is in stop.
   localparam int SOP_BIT_ST_HOLD    = 1; // Processor is held.
   localparam int SOP_BIT_ST_LONG    = 2; // Long delay in progress.
   localparam int SOP_BIT_ST_MONWAKE = 3; // Last stop ended by monitor.

   // Reset value of the option register.
   localparam logic [7:0] SOP_OPTION_RESET = 8'h00;

   //==============================================================
   // Timing counts, in quad bus clock cycles.
   //==============================================================
   localparam int SOP_SHORT_REC_CYC = 32;   // Short stop recovery.
   localparam int SOP_LONG_REC_CYC  = 4096; // Long recovery and POR.
   localparam int SOP_CNT_W         = 13;   // Holds 0 .. 4096.
   localparam logic [12:0] SOP_SHORT_LAST =
      13'(SOP_SHORT_REC_CYC - 1);
   localparam logic [12:0] SOP_LONG_LAST =
      13'(SOP_LONG_REC_CYC - 1);

   //==============================================================
   // Types.
   //==============================================================
   // Software-visible option fields.
   typedef struct packed {
      logic reserved;           // Reads as zero.
      logic lowvolt_stop_enable;
      logic lowvolt_reset_disable;
      logic lowvolt_power_disable;
      logic lowvolt_trip_select;
      logic short_stop_recovery;
      logic halt_enable;
      logic watchdog_disable;
   } sop_option_s;

   // Power sequencer states.
   typedef enum logic [1:0] {
      SOP_STABILIZE,
      SOP_RUN,
      SOP_STOP,
      SOP_RECOVER
   } sop_state_e;

endpackage : sop_pkg

//--- sop_system_option.sv
// System option register with stop and power-on recovery sequencer.
`timescale 1ns/1ps

module sop_system_option (
   // APB clock and asynchronous power-on reset.
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // APB slave port.
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Reset sources other than power-on.
   input  wire logic                     sys_reset_req,
   // Processor requests.
   input  wire logic                     halt_opcode_seen,
   input  wire logic                     wake_event,
   // Analog supply monitor trip, asynchronous.
   input  wire logic                     lowvolt_trip_async,
   // Processor and system controls.
   output logic                          cpu_hold,
   output logic                          stop_mode,
   output logic                          illegal_opcode,
   output logic                          watchdog_run,
   // Supply monitor controls.
   output logic                          monitor_power,
   output logic                          monitor_trip_5v,
   output logic                          monitor_reset
);
   import sop_pkg::*;

   //===============================================================
   // Declarations.
   //===============================================================
   sop_option_s            opt_reg, opt_next;     // Option fields.
   sop_state_e             state_reg, state_next; // Sequencer state.
   logic [SOP_CNT_W-1:0]   cnt_reg, cnt_next;     // Delay counter.
   logic [SOP_CNT_W-1:0]   last_reg, last_next;   // Final count.
   logic                   long_reg, long_next;   // Long delay flag.
   logic                   monwake_reg, monwake_next; // Wake cause.
   logic                   trip_meta_reg;         // Sync stage one.
   logic                   trip_sync_reg;         // Sync stage two.
   logic [31:0]            prdata_reg, prdata_next;
   logic                   pready_reg, pready_next;
   logic                   pslverr_reg, pslverr_next;
   logic                   illop_reg, illop_next; // Illegal pulse.
   logic                   hold_reg, hold_next;
   logic                   stop_reg, stop_next;
   logic                   wdog_reg, wdog_next;
   logic                   mpwr_reg, mpwr_next;
   logic                   mtrip_reg, mtrip_next;
   logic                   mrst_reg, mrst_next;
   logic                   wr_opt;                // Option write.
   logic                   mon_powered;           // Monitor on now.
   logic                   mon_reset_evt;         // Monitor reset.
   logic                   soft_reset;            // Non-POR reset.

   //===============================================================
   // Trip synchroniser.
   //===============================================================
   // The monitor comparator is analog, so its trip passes two flops
   // before any logic looks at it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_meta_reg <= 1'b0;
         trip_sync_reg <= 1'b0;
      end else begin
         trip_meta_reg <= lowvolt_trip_async;
         trip_sync_reg <= trip_meta_reg;
      end
   end

   //===============================================================
   // Supply monitor gating.
   //===============================================================
   // The monitor is powered unless disabled, and in stop only when
   // the stop option asks for it.
   always_comb begin
      mon_powered = !opt_reg.lowvolt_power_disable;
      if (state_reg == SOP_STOP) begin
         mon_powered = mon_powered &&
                       opt_reg.lowvolt_stop_enable;
      end
      // A trip only resets the device while resets are allowed.
      mon_reset_evt = trip_sync_reg && mon_powered &&
                      !opt_reg.lowvolt_reset_disable;
      soft_reset    = sys_reset_req || mon_reset_evt;
   end

   //===============================================================
   // APB slave.
   //===============================================================
   // No wait state: the answer is registered in the setup cycle so
   // that pready and prdata come straight from flops.
   always_comb begin
      pready_next  = psel && !penable;
      prdata_next  = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (psel && !penable) begin
         if (paddr == SOP_OFS_OPTION) begin
            prdata_next[7:0] = opt_reg;
         end else if (paddr == SOP_OFS_STATUS) begin
            prdata_next[SOP_BIT_ST_STOP]    = (state_reg == SOP_STOP);
            prdata_next[SOP_BIT_ST_HOLD]    = hold_reg;
            prdata_next[SOP_BIT_ST_LONG]    = long_reg;
            prdata_next[SOP_BIT_ST_MONWAKE] = monwake_reg;
         end else begin
            // Unmapped offsets answer with an error and zero data.
            pslverr_next = 1'b1;
         end
      end
      wr_opt = psel && penable && pready_reg && pwrite &&
               (paddr == SOP_OFS_OPTION);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   //===============================================================
   // Option register.
   //===============================================================
   // Any reset other than power-on clears every option but the trip
   // select, which only the asynchronous power-on reset clears. A
   // reset wins over a write in the same cycle.
   always_comb begin
      opt_next = opt_reg;
      if (soft_reset) begin
         opt_next = sop_option_s'(SOP_OPTION_RESET);
         opt_next.lowvolt_trip_select =
            opt_reg.lowvolt_trip_select;
      end else if (wr_opt) begin
         opt_next = sop_option_s'(pwdata[7:0]);
         opt_next.reserved = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_reg <= sop_option_s'(SOP_OPTION_RESET);
      end else begin
         opt_reg <= opt_next;
      end
   end

   //===============================================================
   // Power sequencer.
   //===============================================================
   // The counter runs from zero at the start of a delay and releases
   // the processor on the edge after it reaches the final count, so
   // the hold lasts exactly the selected number of cycles. The quad
   // bus clock is pclk itself, so no prescaler is needed.
   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      last_next    = last_reg;
      long_next    = long_reg;
      monwake_next = monwake_reg;
      illop_next   = 1'b0;
      case (state_reg)
         SOP_STABILIZE: begin
            // Power-on stabilization, same length as long recovery.
            if (cnt_reg == SOP_LONG_LAST) begin
               state_next = SOP_RUN;
               long_next  = 1'b0;
               cnt_next   = '0;
            end else begin
               cnt_next = cnt_reg + 13'd1;
            end
         end
         SOP_RUN: begin
            if (halt_opcode_seen && !soft_reset) begin
               if (opt_reg.halt_enable) begin
                  state_next = SOP_STOP;
               end else begin
                  illop_next = 1'b1;
               end
            end
         end
         SOP_STOP: begin
            cnt_next = '0;
            if (mon_reset_evt) begin
               // A monitor reset always brings the long delay.
               state_next   = SOP_RECOVER;
               last_next    = SOP_LONG_LAST;
               long_next    = 1'b1;
               monwake_next = 1'b1;
            end else if (wake_event || sys_reset_req) begin
               state_next   = SOP_RECOVER;
               monwake_next = 1'b0;
               if (opt_reg.short_stop_recovery) begin
                  last_next = SOP_SHORT_LAST;
                  long_next = 1'b0;
               end else begin
                  last_next = SOP_LONG_LAST;
                  long_next = 1'b1;
               end
            end
         end
         SOP_RECOVER: begin
            if (cnt_reg == last_reg) begin
               state_next = SOP_RUN;
               long_next  = 1'b0;
               cnt_next   = '0;
            end else begin
               cnt_next = cnt_reg + 13'd1;
            end
         end
         default: begin
            state_next = SOP_RUN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= SOP_STABILIZE;
         cnt_reg     <= '0;
         last_reg    <= SOP_LONG_LAST;
         long_reg    <= 1'b1;
         monwake_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         last_reg    <= last_next;
         long_reg    <= long_next;
         monwake_reg <= monwake_next;
      end
   end

   //===============================================================
   // Output registers.
   //===============================================================
   // Every control leaves through a flop fed from the next-cycle values, so
   // the outputs change with the option register, monitor_reset one cycle after it; none of them is timing
   // critical next to the analog monitor's own settling time.
   always_comb begin
      hold_next  = (state_next == SOP_STABILIZE) ||
                   (state_next == SOP_STOP) ||
                   (state_next == SOP_RECOVER);
      stop_next  = (state_next == SOP_STOP);
      wdog_next  = !opt_next.watchdog_disable;
      mpwr_next  = !opt_next.lowvolt_power_disable &&
                   ((state_next != SOP_STOP) ||
                    opt_next.lowvolt_stop_enable);
      mtrip_next = opt_next.lowvolt_trip_select;
      mrst_next  = mon_reset_evt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         illop_reg <= 1'b0;
         hold_reg  <= 1'b1;
         stop_reg  <= 1'b0;
         wdog_reg  <= 1'b0;
         mpwr_reg  <= 1'b0;
         mtrip_reg <= 1'b0;
         mrst_reg  <= 1'b0;
      end else begin
         illop_reg <= illop_next;
         hold_reg  <= hold_next;
         stop_reg  <= stop_next;
         wdog_reg  <= wdog_next;
         mpwr_reg  <= mpwr_next;
         mtrip_reg <= mtrip_next;
         mrst_reg  <= mrst_next;
      end
   end

   // Port connections.
   assign prdata          = prdata_reg;
   assign pready          = pready_reg;
   assign pslverr         = pslverr_reg;
   assign cpu_hold        = hold_reg;
   assign stop_mode       = stop_reg;
   assign illegal_opcode  = illop_reg;
   assign watchdog_run    = wdog_reg;
   assign monitor_power   = mpwr_reg;
   assign monitor_trip_5v = mtrip_reg;
   assign monitor_reset   = mrst_reg;

endmodule : sop_system_option

//--- sop_system_option_assertions.sv
// Port checker for the system option block.
`timescale 1ns/1ps

module sop_system_option_assertions (
   // Clock, reset and APB handshake.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Requests and controls.
   input wire logic sys_reset_req,
   input wire logic halt_opcode_seen,
   input wire logic wake_event,
   input wire logic cpu_hold,
   input wire logic stop_mode,
   input wire logic illegal_opcode,
   input wire logic monitor_trip_5v,
   input wire logic monitor_reset
);
   import sop_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==============================================
   // Length of the hold that follows a stop.
   // ==============================================
   logic [12:0] cnt_reg, cnt_next;   // Held cycles since stop ended.
   logic        from_reg, from_next; // The hold follows a stop.

   // A new stop restarts the count, so only one recovery is seen.
   always_comb begin
      cnt_next  = (!stop_mode && cpu_hold) ? cnt_reg + 13'h1 : 13'h0;
      from_next = stop_mode || (cpu_hold && from_reg);
   end

   // Both registers clear on power-on reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) {cnt_reg, from_reg} <= 14'h0;
      else {cnt_reg, from_reg} <= {cnt_next, from_next};
   end

   // ==============================================
   // Assertions and covers.
   // ==============================================
   halt_effect_a: assert property (
      halt_opcode_seen && !cpu_hold && !stop_mode && !sys_reset_req
      && !monitor_reset |=> stop_mode ^ illegal_opcode)
      else $error("Halt gave neither stop nor trap.");
   trap_pulse_a: assert property (
      illegal_opcode |=> !illegal_opcode)
      else $error("Trap pulse too long.");
   stop_hold_a: assert property (
      $rose(stop_mode) |-> cpu_hold && !illegal_opcode)
      else $error("Stop entered without hold.");
   wake_end_a: assert property (
      stop_mode && wake_event && !sys_reset_req |=> !stop_mode)
      else $error("Wake did not end stop.");
   rec_count_a: assert property (
      $fell(cpu_hold) && from_reg |-> cnt_reg == 13'(SOP_SHORT_REC_CYC)
      || cnt_reg == 13'(SOP_LONG_REC_CYC))
      else $error("Stop recovery of wrong length.");
   rec_bound_a: assert property (
      from_reg |-> cnt_reg <= 13'(SOP_LONG_REC_CYC))
      else $error("Stop recovery overran.");
   ready_time_a: assert property (
      psel && !penable |=> pready)
      else $error("APB answer late.");
   trip_keep_a: assert property (
      sys_reset_req |=> $stable(monitor_trip_5v))
      else $error("Trip select changed by system reset.");
   stop_seen_c: cover property ($rose(stop_mode));
   short_rec_c: cover property ($fell(cpu_hold) && cnt_reg == 13'h20);
   trap_seen_c: cover property (illegal_opcode);
endmodule : sop_system_option_assertions

bind sop_system_option sop_system_option_assertions
   u_sop_system_option_assertions (.pclk, .presetn, .psel, .penable,
   .pready, .sys_reset_req, .halt_opcode_seen, .wake_event, .cpu_hold,
   .stop_mode, .illegal_opcode, .monitor_trip_5v, .monitor_reset);

//--- sop_system_option_tb.sv
// Self-checking testbench for the system option block.
`timescale 1ns/1ps

module sop_system_option_tb;
   import sop_pkg::*;

   // ==============================================
   // Signals and counters.
   // ==============================================
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, wd;
   logic        sys_reset_req, halt_opcode_seen, wake_event, err;
   logic        lowvolt_trip_async, cpu_hold, stop_mode, mrst;
   logic        illegal_opcode, watchdog_run, monitor_power;
   logic        monitor_trip_5v, monitor_reset;
   int          num_errors, n_checks, seed, n;

   sop_system_option u_sop_system_option (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sys_reset_req, .halt_opcode_seen, .wake_event,
      .lowvolt_trip_async, .cpu_hold, .stop_mode, .illegal_opcode,
      .watchdog_run, .monitor_power, .monitor_trip_5v, .monitor_reset);

   // Free-running 10 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Compare and count; an unknown never matches.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Print the counts and the verdict, then stop.
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   // One APB transfer, then one idle cycle so psel never toggles twice.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer however long it takes; a hang is left to
      // the watchdog process.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask : apb

   // Write the options, pulse a halt and look at the answer.
   task automatic halt(input logic [7:0] opt);
      apb(1'b1, SOP_OFS_OPTION, {24'h0, opt});
      halt_opcode_seen <= 1'b1;
      @(posedge pclk);
      halt_opcode_seen <= 1'b0;
      @(posedge pclk);
      check(stop_mode, opt[1]);
      check(illegal_opcode, !opt[1]);
      check(cpu_hold, opt[1]);
      check(monitor_power, !opt[4] && (opt[6] || !opt[1]));
   endtask : halt

   // Wait for stop to end, then measure the hold from that point.
   task automatic recover(input int exp, input logic exp_rst);
      mrst = 1'b0;
      n = 0;
      while (stop_mode === 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
         mrst |= monitor_reset;
      end
      {wake_event, lowvolt_trip_async} <= 2'b00;
      n = 0;
      while (cpu_hold === 1'b1 && n < 5000) begin
         @(posedge pclk);
         n++;
         mrst |= monitor_reset;
      end
      check(n, exp);
      check(mrst, exp_rst);
   endtask : recover

   // Main sequence.
   initial begin
      {psel, penable, pwrite, sys_reset_req, halt_opcode_seen} = '0;
      {wake_event, lowvolt_trip_async, paddr, pwdata} = '0;
      {num_errors, n_checks, seed, presetn} = {32'd0, 32'd0, 32'd83, 1'b0};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      n = 0;
      while (cpu_hold === 1'b1 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      // The hold lasts the full delay; one more edge sees it low.
      check(n, SOP_LONG_REC_CYC + 1);
      apb(1'b0, SOP_OFS_OPTION, 32'h0);
      check(rd, {24'h0, SOP_OPTION_RESET});
      check({watchdog_run, monitor_power, monitor_trip_5v}, 3'b110);
      // Random option values; upper write bits must be ignored.
      for (int i = 0; i < 12; i++) begin
         wd = $random(seed);
         apb(1'b1, SOP_OFS_OPTION, wd);
         apb(1'b0, SOP_OFS_OPTION, 32'h0);
         check(rd, {25'h0, wd[6:0]});
         check(watchdog_run, !wd[SOP_BIT_WDOG_DIS]);
         check(monitor_trip_5v, wd[SOP_BIT_TRIP_SEL]);
         check(monitor_power, !wd[SOP_BIT_PWR_DIS]);
      end
      apb(1'b0, 8'h08, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, SOP_OFS_STATUS, 32'hFF);
      apb(1'b0, SOP_OFS_STATUS, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, SOP_OFS_OPTION, 32'h7F);
      sys_reset_req <= 1'b1;
      repeat (3) @(posedge pclk);
      sys_reset_req <= 1'b0;
      apb(1'b0, SOP_OFS_OPTION, 32'h0);
      check(rd, 32'h08);
      halt(8'h00);
      // Short recovery with the monitor off in stop: software must
      // know the monitor turns on within the short delay.
      halt(8'h06);
      wake_event <= 1'b1;
      recover(SOP_SHORT_REC_CYC, 1'b0);
      halt(8'h42);
      wake_event <= 1'b1;
      recover(SOP_LONG_REC_CYC, 1'b0);
      halt(8'h46);
      lowvolt_trip_async <= 1'b1;
      recover(SOP_LONG_REC_CYC, 1'b1);
      // The status must name the monitor as the cause of the wake.
      apb(1'b0, SOP_OFS_STATUS, 32'h0);
      check(rd, 32'h1 << SOP_BIT_ST_MONWAKE);
      // The monitor reset cleared the stop option with the others.
      apb(1'b0, SOP_OFS_OPTION, 32'h0);
      check(rd, {24'h0, SOP_OPTION_RESET});
      halt(8'h66);
      lowvolt_trip_async <= 1'b1;
      repeat (10) @(posedge pclk);
      check(stop_mode, 1'b1);
      {lowvolt_trip_async, wake_event} <= 2'b01;
      recover(SOP_SHORT_REC_CYC, 1'b0);
      complete_run();
   end

   // Cut a hang short well past the expected run length.
   initial begin
      repeat (40000) @(posedge pclk);
      num_errors++;
      complete_run();
   end
endmodule : sop_system_option_tb
